/* dag_top.sv */
// What this block does
// (RULE1) direct address is page bit over offset
// (RULE2) bits 15-8 opcode; bit7 zero means direct
// (RULE3) bit7 one means indirect pointer control
// (RULE4) indirect address is selected pointer low byte
// (RULE5) select bit zero picks pointer zero, else one
// (RULE6) control bit3 clear copies bit0 into select
// (RULE7) control bit5 alone increments active pointer afterwards
// (RULE8) control bit4 alone decrements active pointer afterwards
// (RULE9) bits 5,4 clear leave pointers alone
// (RULE10) source keeps reserved bits 6,2,1 zero
// (RULE11) update runs in parallel, access uses old
// (RULE12) software must load page bit itself
// (RULE13) page bit loadable by three ops, storable
// (RULE14) branch, immediate, no-operand skip modes
// (RULE15) five immediates single cycle, constants from word
// (RULE16) add-with-shift count comes from bits 11-8
// (RULE17) pointers hold 8 bits; load, modify, store
// (RULE18) acc immediate load zeroes upper bits
// (RULE19) prefix 100 marks multiply immediate, 13-bit constant
// (RULE20) pointer steps wrap modulo 256, no flag
`timescale 1ns/1ps
module dag_top #(
  parameter int ACC_W = 32,
  parameter int PTR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // instruction issue
  input wire logic [dag_pkg::INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  // data ram
  output logic [dag_pkg::ADDR_W-1:0] dmem_addr_o,
  output logic dmem_en_o,
  output logic dmem_we_o,
  output logic [dag_pkg::INSTR_W-1:0] dmem_wdata_o,
  input wire logic [dag_pkg::INSTR_W-1:0] dmem_rdata_i,
  // datapath side
  output logic [ACC_W-1:0] acc_o,
  output logic add_go_o,
  output logic [dag_pkg::SHIFT_W-1:0] add_shift_o,
  output logic mul_go_o,
  output logic [dag_pkg::MULK_W-1:0] mul_const_o,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (ACC_W < dag_pkg::IMM8_W || ACC_W > 32)
    $error("dag_top: ACC_W must lie between 8 and the 32-bit bus width");
  if (PTR_W != dag_pkg::ADDR_W)
    $error("dag_top: PTR_W must equal the 8-bit data address width");

  // ****************************************************************
  // decode
  // ****************************************************************
  dag_dec_if dec_if ();

  dag_decode u_decode (
    .instr_i(instr_i),
    .dec(dec_if)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  logic page_reg;
  logic sel_reg;
  logic rsv_reg;
  logic [PTR_W-1:0] ptr_reg [2];
  logic [PTR_W-1:0] ptr_next [2];
  logic [ACC_W-1:0] acc_reg;
  logic [dag_pkg::ADDR_W-1:0] addr_reg;
  logic men_reg;
  logic mwe_reg;
  logic [dag_pkg::INSTR_W-1:0] wdata_reg;
  logic add_reg;
  logic [dag_pkg::SHIFT_W-1:0] shift_reg;
  logic mul_reg;
  logic [dag_pkg::MULK_W-1:0] mulk_reg;
  logic ld_page_reg;
  logic ld_stat_reg;
  logic ld_ptr_reg;
  logic ld_num_reg;
  logic [31:0] prdata_reg;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // true when the offset names a mapped register
  function automatic logic dag_reg_hit(input logic [7:0] a);
    dag_reg_hit = (a == dag_pkg::REG_STATUS_OFS) || (a == dag_pkg::REG_PTR0_OFS) ||
                  (a == dag_pkg::REG_PTR1_OFS) || (a == dag_pkg::REG_LAST_ADDR_OFS) ||
                  (a == dag_pkg::REG_ACC_OFS);
  endfunction

  logic apb_wr;
  logic wr_status;
  logic [1:0] wr_ptr;
  logic [31:0] rd_mux;

  // write strobe lands on the access edge only
  assign apb_wr = psel_i & penable_i & pwrite_i & dag_reg_hit(paddr_i);
  assign wr_status = apb_wr & (paddr_i == dag_pkg::REG_STATUS_OFS);
  assign wr_ptr[0] = apb_wr & (paddr_i == dag_pkg::REG_PTR0_OFS);
  assign wr_ptr[1] = apb_wr & (paddr_i == dag_pkg::REG_PTR1_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~dag_reg_hit(paddr_i);

  // ****************************************************************
  // instruction qualifiers
  // ****************************************************************
  logic go;
  logic step;
  logic [dag_pkg::ADDR_W-1:0] eff_addr;
  logic [dag_pkg::INSTR_W-1:0] status_word;
  logic sel_now;

  assign go = instr_valid_i;
  assign sel_now = sel_reg; // [RULE5]
  // indirect access steps the active pointer only when exactly one of bits 5,4 is set
  assign step = go & dec_if.indirect & (dec_if.inc ^ dec_if.dec); // [RULE9]
  // old pointer or page feeds the access, updates land at the edge
  assign eff_addr = dec_if.indirect ? ptr_reg[sel_now][dag_pkg::ADDR_W-1:0] // [RULE4] [RULE11]
                                    : {page_reg, dec_if.offset}; // [RULE1]
  // status word as stored to memory
  always_comb
  begin
    status_word = 16'h0000;
    status_word[dag_pkg::STAT_PAGE_POS] = page_reg; // [RULE13]
    status_word[dag_pkg::STAT_SEL_POS] = sel_reg;
  end

  // ****************************************************************
  // page bit
  // ****************************************************************
  // newer instruction wins over a memory load landing at the same edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      page_reg <= dag_pkg::RST_PAGE;
    else if (go && dec_if.op == dag_pkg::DAG_OP_LOAD_PAGE_IMM)
      page_reg <= dec_if.imm8[0]; // [RULE13] [RULE15]
    else if (ld_page_reg)
      page_reg <= dmem_rdata_i[0]; // [RULE13]
    else if (ld_stat_reg)
      page_reg <= dmem_rdata_i[dag_pkg::STAT_PAGE_POS]; // [RULE13]
    else if (wr_status)
      page_reg <= pwdata_i[dag_pkg::STAT_PAGE_POS];
  end

  // ****************************************************************
  // pointer select bit
  // ****************************************************************
  // reselection takes effect after the current access
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sel_reg <= dag_pkg::RST_SEL;
    else if (go && dec_if.indirect && !dec_if.keep_sel)
      sel_reg <= dec_if.new_sel; // [RULE6] [RULE11]
    else if (go && dec_if.op == dag_pkg::DAG_OP_LOAD_SELECT_IMM)
      sel_reg <= dec_if.imm8[0]; // [RULE15]
    else if (ld_stat_reg)
      sel_reg <= dmem_rdata_i[dag_pkg::STAT_SEL_POS];
    else if (wr_status)
      sel_reg <= pwdata_i[dag_pkg::STAT_SEL_POS];
  end

  // ****************************************************************
  // reserved-bit sticky flag
  // ****************************************************************
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rsv_reg <= 1'b0;
    else if (go && dec_if.rsv_bad)
      rsv_reg <= 1'b1; // [RULE10]
    else if (wr_status && pwdata_i[dag_pkg::STAT_RSV_POS])
      rsv_reg <= 1'b0;
  end

  // ****************************************************************
  // auxiliary pointers
  // ****************************************************************
  for (genvar i = 0; i < 2; i++)
  begin : g_ptr
    // next value: immediate load, step, memory load, then apb
    always_comb
    begin
      ptr_next[i] = ptr_reg[i];
      if (go && dec_if.op == dag_pkg::DAG_OP_LOAD_PTR_IMM && dec_if.ptr_num == 1'(i))
        ptr_next[i] = dec_if.imm8; // [RULE15] [RULE17]
      else if (step && sel_now == 1'(i) && dec_if.inc)
        ptr_next[i] = ptr_reg[i] + 8'h01; // [RULE7] [RULE20]
      else if (step && sel_now == 1'(i) && dec_if.dec)
        ptr_next[i] = ptr_reg[i] - 8'h01; // [RULE8] [RULE20]
      else if (ld_ptr_reg && ld_num_reg == 1'(i))
        ptr_next[i] = dmem_rdata_i[PTR_W-1:0]; // [RULE17]
      else if (wr_ptr[i])
        ptr_next[i] = pwdata_i[PTR_W-1:0];
    end

    // pointer storage
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        ptr_reg[i] <= dag_pkg::RST_PTR;
      else
        ptr_reg[i] <= ptr_next[i]; // [RULE11] [RULE17]
    end
  end

  // ****************************************************************
  // data ram request
  // ****************************************************************
  // one access per memory-operand instruction except modify-pointer, held for one cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      addr_reg <= 8'h00;
      men_reg <= 1'b0;
      mwe_reg <= 1'b0;
      wdata_reg <= 16'h0000;
    end
    else
    begin
      men_reg <= go && dec_if.mem_op && dec_if.op != dag_pkg::DAG_OP_MODIFY_PTR; // [RULE14]
      mwe_reg <= go && (dec_if.op == dag_pkg::DAG_OP_STORE_PTR ||
                        dec_if.op == dag_pkg::DAG_OP_STORE_STATUS);
      if (go && dec_if.mem_op)
        addr_reg <= eff_addr; // [RULE1] [RULE4]
      if (go && dec_if.op == dag_pkg::DAG_OP_STORE_PTR)
        wdata_reg <= {8'h00, ptr_reg[dec_if.ptr_num]}; // [RULE17]
      else if (go && dec_if.op == dag_pkg::DAG_OP_STORE_STATUS)
        wdata_reg <= status_word; // [RULE13]
    end
  end

  // ****************************************************************
  // pending memory loads
  // ****************************************************************
  // read data returns during the access cycle and lands at its end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ld_page_reg <= 1'b0;
      ld_stat_reg <= 1'b0;
      ld_ptr_reg <= 1'b0;
      ld_num_reg <= 1'b0;
    end
    else
    begin
      ld_page_reg <= go && dec_if.op == dag_pkg::DAG_OP_LOAD_PAGE; // [RULE13]
      ld_stat_reg <= go && dec_if.op == dag_pkg::DAG_OP_LOAD_STATUS; // [RULE13]
      ld_ptr_reg <= go && dec_if.op == dag_pkg::DAG_OP_LOAD_PTR; // [RULE17]
      ld_num_reg <= dec_if.ptr_num;
    end
  end

  // ****************************************************************
  // accumulator immediate load
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      acc_reg <= '0;
    else if (go && dec_if.op == dag_pkg::DAG_OP_ACC_LOAD_IMM)
      acc_reg <= {{(ACC_W-dag_pkg::IMM8_W){1'b0}}, dec_if.imm8}; // [RULE18] [RULE15]
  end

  // ****************************************************************
  // datapath strobes
  // ****************************************************************
  // shift count and multiply constant travel with one-cycle strobes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      add_reg <= 1'b0;
      shift_reg <= 4'h0;
      mul_reg <= 1'b0;
      mulk_reg <= 13'h0000;
    end
    else
    begin
      add_reg <= go && dec_if.op == dag_pkg::DAG_OP_ADD_SHIFT;
      mul_reg <= go && dec_if.op == dag_pkg::DAG_OP_MUL_IMM; // [RULE19]
      if (go && dec_if.op == dag_pkg::DAG_OP_ADD_SHIFT)
        shift_reg <= dec_if.shift; // [RULE16]
      if (go && dec_if.op == dag_pkg::DAG_OP_MUL_IMM)
        mulk_reg <= dec_if.mulk; // [RULE15] [RULE19]
    end
  end

  // ****************************************************************
  // apb read data
  // ****************************************************************
  // read mux over block state
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      dag_pkg::REG_STATUS_OFS:
      begin
        rd_mux[dag_pkg::STAT_PAGE_POS] = page_reg;
        rd_mux[dag_pkg::STAT_SEL_POS] = sel_reg;
        rd_mux[dag_pkg::STAT_RSV_POS] = rsv_reg;
      end
      dag_pkg::REG_PTR0_OFS: rd_mux[PTR_W-1:0] = ptr_reg[0];
      dag_pkg::REG_PTR1_OFS: rd_mux[PTR_W-1:0] = ptr_reg[1];
      dag_pkg::REG_LAST_ADDR_OFS: rd_mux[dag_pkg::ADDR_W-1:0] = addr_reg;
      dag_pkg::REG_ACC_OFS: rd_mux[ACC_W-1:0] = acc_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // capture in the setup cycle, stable through the access phase
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prdata_reg <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
      prdata_reg <= rd_mux;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign dmem_addr_o = addr_reg;
  assign dmem_en_o = men_reg;
  assign dmem_we_o = mwe_reg;
  assign dmem_wdata_o = wdata_reg;
  assign acc_o = acc_reg;
  assign add_go_o = add_reg;
  assign add_shift_o = shift_reg;
  assign mul_go_o = mul_reg;
  assign mul_const_o = mulk_reg;
  assign prdata_o = prdata_reg;

endmodule

/* dag_pkg.sv */
package dag_pkg;

  // ****************************************************************
  // instruction word layout
  // ****************************************************************
  localparam int INSTR_W = 16;
  localparam int MODE_POS = 7;
  localparam int CTL_INC_POS = 5;
  localparam int CTL_DEC_POS = 4;
  localparam int CTL_KEEP_POS = 3;
  localparam int CTL_NEWSEL_POS = 0;
  localparam logic [6:0] CTL_RSV_MASK = 7'h46;
  localparam int PTR_NUM_POS = 8;
  localparam int ADDR_W = 8;
  localparam int OFS_W = 7;
  localparam int SHIFT_W = 4;
  localparam int MULK_W = 13;
  localparam int IMM8_W = 8;

  // ****************************************************************
  // opcode values of the high byte
  // ****************************************************************
  localparam logic [3:0] OPC_ADD_SHIFT_HI = 4'h0;
  localparam logic [2:0] OPC_MUL_IMM_HI = 3'h4;
  localparam logic [3:0] OPC_BRANCH_HI = 4'hf;
  localparam logic [7:0] OPC_NO_OPERAND = 8'h7f;
  localparam logic [7:0] OPC_ACC_LOAD_IMM = 8'h7e;
  localparam logic [6:0] OPC_LOAD_PTR_HI = 7'h1c;
  localparam logic [6:0] OPC_STORE_PTR_HI = 7'h18;
  localparam logic [6:0] OPC_LOAD_PTR_IMM_HI = 7'h38;
  localparam logic [7:0] OPC_LOAD_PAGE = 8'h6f;
  localparam logic [7:0] OPC_LOAD_PAGE_IMM = 8'h6e;
  localparam logic [7:0] OPC_LOAD_STATUS = 8'h7b;
  localparam logic [7:0] OPC_STORE_STATUS = 8'h7c;
  localparam logic [7:0] OPC_LOAD_SELECT_IMM = 8'h6a;
  localparam logic [7:0] OPC_MODIFY_PTR = 8'h68;

  // ****************************************************************
  // operation classes
  // ****************************************************************
  typedef enum logic [3:0] {
    DAG_OP_OTHER = 4'h0,
    DAG_OP_ADD_SHIFT = 4'h1,
    DAG_OP_LOAD_PAGE = 4'h2,
    DAG_OP_LOAD_PAGE_IMM = 4'h3,
    DAG_OP_LOAD_STATUS = 4'h4,
    DAG_OP_STORE_STATUS = 4'h5,
    DAG_OP_LOAD_PTR = 4'h6,
    DAG_OP_LOAD_PTR_IMM = 4'h7,
    DAG_OP_LOAD_SELECT_IMM = 4'h8,
    DAG_OP_MODIFY_PTR = 4'h9,
    DAG_OP_STORE_PTR = 4'ha,
    DAG_OP_ACC_LOAD_IMM = 4'hb,
    DAG_OP_MUL_IMM = 4'hc,
    DAG_OP_BRANCH = 4'hd,
    DAG_OP_NO_OPERAND = 4'he
  } dag_op_t;

  // ****************************************************************
  // status word and apb map
  // ****************************************************************
  localparam int STAT_PAGE_POS = 0;
  localparam int STAT_SEL_POS = 1;
  localparam int STAT_RSV_POS = 2;
  localparam logic [7:0] REG_STATUS_OFS = 8'h00;
  localparam logic [7:0] REG_PTR0_OFS = 8'h04;
  localparam logic [7:0] REG_PTR1_OFS = 8'h08;
  localparam logic [7:0] REG_LAST_ADDR_OFS = 8'h0c;
  localparam logic [7:0] REG_ACC_OFS = 8'h10;
  localparam logic RST_PAGE = 1'b0;
  localparam logic RST_SEL = 1'b0;
  localparam logic [7:0] RST_PTR = 8'h00;

endpackage

/* dag_dec_if.sv */
`timescale 1ns/1ps
interface dag_dec_if;
  logic mem_op;
  logic indirect;
  dag_pkg::dag_op_t op;
  logic [dag_pkg::OFS_W-1:0] offset;
  logic inc;
  logic dec;
  logic keep_sel;
  logic new_sel;
  logic ptr_num;
  logic rsv_bad;
  logic [dag_pkg::IMM8_W-1:0] imm8;
  logic [dag_pkg::MULK_W-1:0] mulk;
  logic [dag_pkg::SHIFT_W-1:0] shift;

  modport dec_mp (
    output mem_op, indirect, op, offset, inc, dec, keep_sel, new_sel,
    output ptr_num, rsv_bad, imm8, mulk, shift
  );
  modport core_mp (
    input mem_op, indirect, op, offset, inc, dec, keep_sel, new_sel,
    input ptr_num, rsv_bad, imm8, mulk, shift
  );
endinterface

/* dag_decode.sv */
`timescale 1ns/1ps
module dag_decode (
  // instruction word
  input wire logic [dag_pkg::INSTR_W-1:0] instr_i,
  // decoded fields
  dag_dec_if.dec_mp dec
);

  // ****************************************************************
  // opcode classification
  // ****************************************************************
  logic [7:0] hi;
  assign hi = instr_i[15:8];

  // sort the high byte into operation classes
  always_comb
  begin
    dec.op = dag_pkg::DAG_OP_OTHER;
    dec.mem_op = 1'b1;
    if (hi[7:4] == dag_pkg::OPC_ADD_SHIFT_HI)
      dec.op = dag_pkg::DAG_OP_ADD_SHIFT;
    else if (hi[7:5] == dag_pkg::OPC_MUL_IMM_HI)
    begin
      dec.op = dag_pkg::DAG_OP_MUL_IMM; // [RULE19]
      dec.mem_op = 1'b0;
    end
    else if (hi[7:4] == dag_pkg::OPC_BRANCH_HI)
    begin
      dec.op = dag_pkg::DAG_OP_BRANCH; // [RULE14]
      dec.mem_op = 1'b0;
    end
    else if (hi == dag_pkg::OPC_NO_OPERAND)
    begin
      dec.op = dag_pkg::DAG_OP_NO_OPERAND; // [RULE14]
      dec.mem_op = 1'b0;
    end
    else if (hi == dag_pkg::OPC_ACC_LOAD_IMM)
    begin
      dec.op = dag_pkg::DAG_OP_ACC_LOAD_IMM; // [RULE15]
      dec.mem_op = 1'b0;
    end
    else if (hi[7:1] == dag_pkg::OPC_LOAD_PTR_IMM_HI)
    begin
      dec.op = dag_pkg::DAG_OP_LOAD_PTR_IMM; // [RULE15]
      dec.mem_op = 1'b0;
    end
    else if (hi == dag_pkg::OPC_LOAD_PAGE_IMM)
    begin
      dec.op = dag_pkg::DAG_OP_LOAD_PAGE_IMM; // [RULE15]
      dec.mem_op = 1'b0;
    end
    else if (hi == dag_pkg::OPC_LOAD_SELECT_IMM)
    begin
      dec.op = dag_pkg::DAG_OP_LOAD_SELECT_IMM; // [RULE15]
      dec.mem_op = 1'b0;
    end
    else if (hi[7:1] == dag_pkg::OPC_LOAD_PTR_HI)
      dec.op = dag_pkg::DAG_OP_LOAD_PTR;
    else if (hi[7:1] == dag_pkg::OPC_STORE_PTR_HI)
      dec.op = dag_pkg::DAG_OP_STORE_PTR;
    else if (hi == dag_pkg::OPC_LOAD_PAGE)
      dec.op = dag_pkg::DAG_OP_LOAD_PAGE;
    else if (hi == dag_pkg::OPC_LOAD_STATUS)
      dec.op = dag_pkg::DAG_OP_LOAD_STATUS;
    else if (hi == dag_pkg::OPC_STORE_STATUS)
      dec.op = dag_pkg::DAG_OP_STORE_STATUS;
    else if (hi == dag_pkg::OPC_MODIFY_PTR)
      dec.op = dag_pkg::DAG_OP_MODIFY_PTR;
  end

  // ****************************************************************
  // operand fields
  // ****************************************************************
  // mode bit only counts for memory-operand classes
  assign dec.indirect = dec.mem_op & instr_i[dag_pkg::MODE_POS]; // [RULE2] [RULE3] [RULE14]
  assign dec.offset = instr_i[dag_pkg::OFS_W-1:0]; // [RULE2]
  assign dec.inc = instr_i[dag_pkg::CTL_INC_POS]; // [RULE7]
  assign dec.dec = instr_i[dag_pkg::CTL_DEC_POS]; // [RULE8]
  assign dec.keep_sel = instr_i[dag_pkg::CTL_KEEP_POS]; // [RULE6]
  assign dec.new_sel = instr_i[dag_pkg::CTL_NEWSEL_POS]; // [RULE6]
  assign dec.ptr_num = instr_i[dag_pkg::PTR_NUM_POS];
  // reserved control bits seen set by an indirect access
  assign dec.rsv_bad = dec.indirect & (|(instr_i[6:0] & dag_pkg::CTL_RSV_MASK)); // [RULE10]
  assign dec.imm8 = instr_i[dag_pkg::IMM8_W-1:0]; // [RULE15]
  assign dec.mulk = instr_i[dag_pkg::MULK_W-1:0]; // [RULE15] [RULE19]
  assign dec.shift = instr_i[11:8]; // [RULE16]

endmodule

/* dag_top_asserts.sv */
`timescale 1ns/1ps
module dag_top_asserts #(
  parameter int ACC_W = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // instruction issue
  input wire logic [dag_pkg::INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  // data ram and datapath
  input wire logic [dag_pkg::ADDR_W-1:0] dmem_addr_o,
  input wire logic dmem_en_o,
  input wire logic [ACC_W-1:0] acc_o,
  input wire logic add_go_o,
  input wire logic [dag_pkg::SHIFT_W-1:0] add_shift_o,
  input wire logic mul_go_o,
  input wire logic [dag_pkg::MULK_W-1:0] mul_const_o,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ****************************************************************
  // indirect add-shift issue with a given step/keep field
  // ****************************************************************
  sequence ind_s(logic [2:0] ctl);
    instr_valid_i && instr_i[15:12] == 4'h0 && instr_i[7] && !instr_i[6] && instr_i[5:3] == ctl;
  endsequence
  // second access sees the pointer stepped by the first
  property step_p(logic [2:0] ctl, logic [7:0] delta);
    ind_s(ctl) ##1 ind_s(3'b001) |=> dmem_addr_o == $past(dmem_addr_o) + delta;
  endproperty

  // ****************************************************************
  // checks
  // ****************************************************************
  step_inc_a: assert property (step_p(3'b101, 8'h01)) else $error("pointer not incremented");
  step_dec_a: assert property (step_p(3'b011, 8'hff)) else $error("pointer not decremented");
  step_hold_a: assert property (step_p(3'b001, 8'h00)) else $error("pointer changed");
  acc_load_a: assert property (instr_valid_i && instr_i[15:8] == 8'h7e |=>
    acc_o == {{(ACC_W-8){1'b0}}, $past(instr_i[7:0])}) else $error("acc load wrong");
  mul_const_a: assert property (instr_valid_i && instr_i[15:13] == 3'b100 |=>
    mul_go_o && mul_const_o == $past(instr_i[12:0])) else $error("multiply wrong");
  add_shift_a: assert property (instr_valid_i && instr_i[15:12] == 4'h0 |=>
    add_go_o && add_shift_o == $past(instr_i[11:8])) else $error("shift wrong");
  branch_noram_a: assert property (instr_valid_i && instr_i[15:12] == 4'hf |=> !dmem_en_o)
    else $error("branch touched ram");
  direct_ofs_a: assert property (instr_valid_i && instr_i[15:12] == 4'h0 && !instr_i[7] |=>
    dmem_en_o && dmem_addr_o[6:0] == $past(instr_i[6:0])) else $error("offset wrong");
  strobe_idle_a: assert property (!instr_valid_i |=> !dmem_en_o && !add_go_o && !mul_go_o)
    else $error("strobe without issue");
  apb_ready_a: assert property (psel_i && penable_i |-> pready_o) else $error("no ready");
  apb_err_a: assert property (psel_i && penable_i && paddr_i[1:0] == 2'b00 |->
    pslverr_o == (paddr_i > 8'h10)) else $error("slave error wrong");
endmodule

bind dag_top dag_top_asserts #(.ACC_W(ACC_W)) i_dag_top_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
  .dmem_addr_o(dmem_addr_o), .dmem_en_o(dmem_en_o), .acc_o(acc_o), .add_go_o(add_go_o),
  .add_shift_o(add_shift_o), .mul_go_o(mul_go_o), .mul_const_o(mul_const_o),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o)
);

/* dag_ram_model.sv */
`timescale 1ns/1ps
module dag_ram_model (
  // clock
  input wire logic clk_i,
  // ram port
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [256];

  // preset: inverse of the address in the low byte
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = {8'h00, ~8'(i)};
  end

  // write on the strobe edge
  always @(posedge clk_i)
  begin
    if (en_i && we_i) mem[addr_i] <= wdata_i;
  end

  // async read; a deselected port shows the inverse
  assign rdata_o = en_i ? mem[addr_i] : ~mem[addr_i];
endmodule

/* dag_top_test.sv */
`timescale 1ns/1ps
module dag_top_test;
  // ****************************************************************
  // signals and counters
  // ****************************************************************
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic instr_valid_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [7:0] dmem_addr_o;
  logic [15:0] dmem_wdata_o, dmem_rdata_i;
  logic [31:0] acc_o, prdata_o, rd;
  logic dmem_en_o, dmem_we_o, add_go_o, mul_go_o, pready_o, pslverr_o, err;
  logic [3:0] add_shift_o;
  logic [12:0] mul_const_o;
  int failures = 0;
  int checks = 0;

  always #4 clk_i = ~clk_i;

  dag_top i_dag_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .dmem_addr_o(dmem_addr_o), .dmem_en_o(dmem_en_o),
    .dmem_we_o(dmem_we_o), .dmem_wdata_o(dmem_wdata_o), .dmem_rdata_i(dmem_rdata_i),
    .acc_o(acc_o), .add_go_o(add_go_o), .add_shift_o(add_shift_o), .mul_go_o(mul_go_o),
    .mul_const_o(mul_const_o), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o));
  dag_ram_model i_dag_ram_model (.clk_i(clk_i), .en_i(dmem_en_o), .we_i(dmem_we_o),
    .addr_i(dmem_addr_o), .wdata_i(dmem_wdata_o), .rdata_o(dmem_rdata_i));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  // one or two back-to-back instructions; outputs of the last are settled on return
  task issue(input logic [15:0] a, input logic [15:0] b = 16'h0000, input bit two = 1'b0);
    @(posedge clk_i);
    instr_i <= a;
    instr_valid_i <= 1'b1;
    if (two)
    begin
      @(posedge clk_i);
      instr_i <= b;
    end
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // scenarios; reserved indirect bits are always sent as zero
  // ****************************************************************
  task test_direct();
    issue(16'h6e01); // page loaded before any direct access
    issue(16'h0515);
    check(dmem_addr_o, 32'h95);
    issue(16'h6f03);
    issue(16'h6015);
    check(dmem_addr_o, 32'h15);
    issue(16'h7b02);
    issue(16'h6015);
    check(dmem_addr_o, 32'h95);
  endtask

  task test_indirect();
    issue(16'h7005);
    issue(16'h395f);
    issue(16'h08a8);
    check({add_go_o, add_shift_o, dmem_addr_o}, 32'h1805);
    apb(1'b0, dag_pkg::REG_PTR0_OFS, 32'h0);
    check(rd, 32'h06);
    issue(16'h08a1, 16'h0898, 1'b1);
    check(dmem_addr_o, 32'h20);
    apb(1'b0, dag_pkg::REG_PTR1_OFS, 32'h0);
    check(rd, 32'h1f);
    apb(1'b0, dag_pkg::REG_PTR0_OFS, 32'h0);
    check(rd, 32'h07);
    issue(16'h6888, 16'h7c01, 1'b1);
    check({dmem_we_o, dmem_wdata_o}, 32'h10003);
    apb(1'b0, dag_pkg::REG_PTR1_OFS, 32'h0);
    check(rd, 32'h1f);
  endtask

  task test_wrap();
    issue(16'h71ff);
    issue(16'h08a8, 16'h0888, 1'b1);
    check(dmem_addr_o, 32'h00);
    issue(16'h0898, 16'h0888, 1'b1);
    check(dmem_addr_o, 32'hff);
    issue(16'h0888, 16'h0888, 1'b1);
    check(dmem_addr_o, 32'hff);
  endtask

  task test_imm();
    issue(16'h7edd);
    check(acc_o, 32'hdd);
    issue(16'h8add);
    check({mul_go_o, mul_const_o}, 32'h2add);
    issue(16'hf080);
    check(dmem_en_o, 32'h0);
    issue(16'h6a00, 16'h0888, 1'b1);
    check(dmem_addr_o, 32'h07);
  endtask

  task test_apb();
    apb(1'b1, dag_pkg::REG_PTR0_OFS, 32'h42);
    apb(1'b0, dag_pkg::REG_PTR0_OFS, 32'h0);
    check(rd, 32'h42);
    apb(1'b1, 8'h20, 32'h1);
    check(err, 32'h1);
    apb(1'b0, dag_pkg::REG_ACC_OFS, 32'h0);
    check(rd, 32'hdd);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    test_direct();
    test_indirect();
    test_wrap();
    test_imm();
    test_apb();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    give_verdict();
  end
endmodule
